//--- rtl/pfr_pkg.sv
// Purpose: Shared constants and types for the power-on fault and port
//          remap register bank.
// Assumes: One four-channel group, byte-wide command-addressed registers.
// Notes:   Command codes are the register addresses seen by the host.
package pfr_pkg;

    localparam int PFR_NUM_CH = 4;
    localparam int PFR_CODE_W = 2;

    localparam logic [7:0] PFR_CMD_FAULT_RO = 8'h24;
    localparam logic [7:0] PFR_CMD_FAULT_RC = 8'h25;
    localparam logic [7:0] PFR_CMD_REMAP = 8'h26;
    localparam logic [7:0] PFR_CMD_DEV_RESET = 8'h1A;

    localparam logic [7:0] PFR_FAULT_RST = 8'h00;
    localparam logic [7:0] PFR_REMAP_RST = 8'hE4;
    localparam logic [7:0] PFR_UNMAPPED_RD = 8'h00;
    localparam logic [3:0] PFR_ALL_CH = 4'hF;

    typedef enum logic [1:0]
    {
        PFR_FLT_NONE = 2'h0,
        PFR_FLT_DETECT = 2'h1,
        PFR_FLT_CLASS = 2'h2,
        PFR_FLT_POWER = 2'h3
    } pfr_fault_t;

    // One host register access
    typedef struct packed
    {
        logic valid;
        logic write;
        logic [7:0] code;
        logic [7:0] wdata;
    } pfr_cmd_t;

    // Per-channel events from the channel state machines
    typedef struct packed
    {
        logic turn_off;
        logic turnon_fail;
        logic start_fault;
        logic pec_flag;
        logic alloc_denied;
        pfr_fault_t cause;
    } pfr_chan_evt_t;

endpackage : pfr_pkg

//--- rtl/pfr_fault_field.sv
// Purpose: One channel's 2-bit turn-on fault code.
// Assumes: Events are one-cycle pulses on the same clock.
// Notes:   A new fault always beats a clear in the same cycle.
`timescale 1ns/1ns
module pfr_fault_field
    import pfr_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire pfr_chan_evt_t i_evt,
    input wire logic i_read_clear,
    output pfr_fault_t o_code
);

    pfr_fault_t code_reg;
    pfr_fault_t code_next;
    wire logic load_fail;
    wire logic load_start;
    pfr_fault_t load_code;

    assign load_fail = i_evt.turnon_fail;
    assign load_start = i_evt.start_fault && !i_evt.pec_flag;

    // Allocation refusal overrides the reported cause
    always_comb
    begin
        load_code = i_evt.cause;
        if (i_evt.alloc_denied)
        begin
            load_code = PFR_FLT_POWER;
        end
    end

    always_comb
    begin
        code_next = code_reg;
        if (load_fail || load_start)
        begin
            code_next = load_code;
        end
        else if (i_evt.turn_off || i_read_clear)
        begin
            code_next = PFR_FLT_NONE;
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            code_reg <= PFR_FLT_NONE;
        end
        else
        begin
            code_reg <= code_next;
        end
    end

    assign o_code = code_reg;

endmodule : pfr_fault_field

//--- rtl/pfr_top.sv
// Purpose: Power-on fault status and logical-to-physical channel map
//          registers for one four-channel group.
// Assumes: Host accesses arrive decoded, one byte per command code.
// Notes:   Map survives device reset; only power-on reset restores it.
`timescale 1ns/1ns
module pfr_top
    import pfr_pkg::*;
#(
    parameter int NUM_CH = PFR_NUM_CH
)
(
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_por_rst,
    input wire pfr_cmd_t i_cmd,
    input wire pfr_chan_evt_t [NUM_CH-1:0] i_chan_evt,
    input wire logic [NUM_CH-1:0] i_chan_off,
    output logic [7:0] o_rdata,
    output logic o_rvalid,
    output logic o_remap_ignored,
    output logic [NUM_CH-1:0][PFR_CODE_W-1:0] o_phys_chan,
    output logic [NUM_CH-1:0][NUM_CH-1:0] o_phys_onehot
);

    logic [7:0] map_reg;
    logic [7:0] rdata_reg;
    logic rvalid_reg;
    logic ignored_reg;
    wire logic [7:0] map_next;
    wire logic [7:0] rdata_next;
    wire logic rvalid_next;
    wire logic ignored_next;
    wire logic [7:0] fault_byte;
    wire logic [NUM_CH-1:0] used_codes;
    wire logic [NUM_CH-1:0][NUM_CH-1:0] code_hit;
    wire logic [NUM_CH-1:0][PFR_CODE_W-1:0] wr_field;
    wire logic [NUM_CH-1:0][PFR_CODE_W-1:0] map_field;
    wire logic any_rst;
    wire logic cmd_rd;
    wire logic cmd_wr;
    wire logic code_ro;
    wire logic code_rc;
    wire logic code_map;
    wire logic code_dev_reset;
    wire logic rd_ro;
    wire logic rd_rc;
    wire logic rd_fault;
    wire logic rd_map;
    wire logic wr_map;
    wire logic map_is_perm;
    wire logic group_off;
    wire logic map_accept;
    wire logic map_refuse;

    // Either reset clears the fault side; only power-on touches the map
    assign any_rst = i_rst || i_por_rst;

    // Direction of the access in flight
    assign cmd_rd = i_cmd.valid && !i_cmd.write;
    assign cmd_wr = i_cmd.valid && i_cmd.write;

    assign code_ro = (i_cmd.code == PFR_CMD_FAULT_RO);
    assign code_rc = (i_cmd.code == PFR_CMD_FAULT_RC);
    assign code_map = (i_cmd.code == PFR_CMD_REMAP);
    assign code_dev_reset = (i_cmd.code == PFR_CMD_DEV_RESET);

    assign rd_ro = cmd_rd && code_ro;
    assign rd_rc = cmd_rd && code_rc;
    assign rd_fault = rd_ro || rd_rc;
    assign rd_map = cmd_rd && code_map;
    // Device reset command is decoded here only to mask the map write; it never reaches the map
    assign wr_map = cmd_wr && code_map && !code_dev_reset;

    genvar g;
    genvar f;
    generate
        for (g = 0; g < NUM_CH; g++)
        begin : g_ch
            pfr_fault_t code;
            pfr_fault_field u_field
            (
                .i_ref_clk(i_ref_clk),
                .i_rst(any_rst),
                .i_evt(i_chan_evt[g]),
                .i_read_clear(rd_rc),
                .o_code(code)
            );
            assign fault_byte[2*g +: PFR_CODE_W] = code;
            assign wr_field[g] = i_cmd.wdata[2*g +: PFR_CODE_W];
            assign map_field[g] = map_reg[2*g +: PFR_CODE_W];
            for (f = 0; f < NUM_CH; f++)
            begin : g_fld
                // Write field f names physical code g
                assign code_hit[g][f] =
                    (wr_field[f] == PFR_CODE_W'(g));
                // Code k drives physical channel k of the group
                assign o_phys_onehot[g][f] =
                    (map_field[g] == PFR_CODE_W'(f));
            end
            assign used_codes[g] = |code_hit[g];
            // Codes only reach the four channels of this group
            assign o_phys_chan[g] = map_field[g];
        end
    endgenerate

    // Every code used once means the write is a full permutation
    assign map_is_perm = (used_codes == PFR_ALL_CH);
    assign group_off = &i_chan_off;
    assign map_accept = wr_map && map_is_perm && group_off;
    assign map_refuse = wr_map && !map_accept;
    assign map_next = map_accept ? i_cmd.wdata : map_reg;

    // Unknown codes read as zero; the byte stands for one cycle only
    assign rdata_next = rd_fault ? fault_byte
        : (rd_map ? map_reg : PFR_UNMAPPED_RD);
    assign rvalid_next = cmd_rd;
    assign ignored_next = map_refuse;

    // Only power-on restores the map; the reset pin leaves it alone
    always_ff @(posedge i_ref_clk)
    begin
        if (i_por_rst)
        begin
            map_reg <= PFR_REMAP_RST;
        end
        else
        begin
            map_reg <= map_next;
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (any_rst)
        begin
            rdata_reg <= PFR_FAULT_RST;
        end
        else
        begin
            rdata_reg <= rdata_next;
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (any_rst)
        begin
            rvalid_reg <= 1'b0;
        end
        else
        begin
            rvalid_reg <= rvalid_next;
        end
    end

    // Refusal is a pulse; the host sees it once per rejected write
    always_ff @(posedge i_ref_clk)
    begin
        if (any_rst)
        begin
            ignored_reg <= 1'b0;
        end
        else
        begin
            ignored_reg <= ignored_next;
        end
    end

    assign o_rdata = rdata_reg;
    assign o_rvalid = rvalid_reg;
    assign o_remap_ignored = ignored_reg;

endmodule : pfr_top

//--- dv/pfr_monitor.sv
// Purpose: Assertions on the fault and map register bank
// Assumes: Sees pfr_top ports only
// Notes: Only a_map_por and a_map_kept run through device reset; the other checks are off during it
`timescale 1ns/1ns
module pfr_monitor
    import pfr_pkg::*;
#(parameter int NUM_CH = 4)
(
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_por_rst,
    input wire pfr_cmd_t i_cmd,
    input wire logic [NUM_CH-1:0] i_chan_off,
    input wire logic o_rvalid,
    input wire logic o_remap_ignored,
    input wire logic [NUM_CH-1:0][PFR_CODE_W-1:0] o_phys_chan,
    input wire logic [NUM_CH-1:0][NUM_CH-1:0] o_phys_onehot
);
    wire logic [7:0] d = i_cmd.wdata;
    wire logic [3:0] s = 4'h1 << d[1:0] | 4'h1 << d[3:2] | 4'h1 << d[5:4]
        | 4'h1 << d[7:6];
    wire logic wm = i_cmd.valid && i_cmd.write && i_cmd.code == PFR_CMD_REMAP;
    wire logic off = i_chan_off == PFR_ALL_CH;
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_rst || i_por_rst);
    a_read_answer: assert property (
        i_cmd.valid && !i_cmd.write |=> o_rvalid) else $error("no answer");
    a_remap_taken: assert property (
        wm && off && s == PFR_ALL_CH |=> o_phys_chan == $past(d)
        && !o_remap_ignored) else $error("remap lost");
    a_remap_busy: assert property (
        wm && !off |=> o_remap_ignored && $stable(o_phys_chan))
        else $error("busy remap");
    a_remap_dup: assert property (
        wm && s != PFR_ALL_CH |=> o_remap_ignored && $stable(o_phys_chan))
        else $error("dup remap");
    a_stray_ignore: assert property (
        !wm |=> !o_remap_ignored) else $error("stray ignore");
    a_route_decode: assert property (
        o_phys_onehot == {4'h1 << o_phys_chan[3], 4'h1 << o_phys_chan[2],
        4'h1 << o_phys_chan[1], 4'h1 << o_phys_chan[0]}) else $error("route");
    a_map_por: assert property (
        @(posedge i_ref_clk) disable iff (1'b0)
        i_por_rst |=> o_phys_chan == PFR_REMAP_RST) else $error("map por");
    a_map_kept: assert property (
        @(posedge i_ref_clk) disable iff (i_por_rst)
        i_rst |=> $stable(o_phys_chan)) else $error("map reset");
endmodule : pfr_monitor
bind pfr_top pfr_monitor #(.NUM_CH(NUM_CH)) u_mon (.i_ref_clk(i_ref_clk),
    .i_rst(i_rst), .i_por_rst(i_por_rst), .i_cmd(i_cmd),
    .i_chan_off(i_chan_off), .o_rvalid(o_rvalid),
    .o_remap_ignored(o_remap_ignored), .o_phys_chan(o_phys_chan),
    .o_phys_onehot(o_phys_onehot));

//--- dv/pfr_host_model.sv
// Purpose: Host issuing byte register commands
// Assumes: One access in flight
// Notes: Valid held for one taking edge
`timescale 1ns/1ns
module pfr_host_model
    import pfr_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic [7:0] i_rdata,
    output pfr_cmd_t o_cmd = '0
);
    task automatic xfer(input logic w, input logic [7:0] c, d,
        output logic [7:0] r);
        @(posedge i_ref_clk);
        o_cmd <= '{1'b1, w, c, d};
        @(posedge i_ref_clk);
        o_cmd.valid <= 1'b0;
        // Answer stands in the cycle after the taking edge
        @(posedge i_ref_clk);
        r = i_rdata;
    endtask : xfer
endmodule : pfr_host_model

//--- dv/poweron_fault_and_port_remap_tb.sv
// Purpose: Bench for fault and map registers
// Assumes: Bench drives channel events
// Notes: Model keeps fault byte and map
`timescale 1ns/1ns
module poweron_fault_and_port_remap_tb
    import pfr_pkg::*;
;
    logic i_ref_clk = 0, i_rst = 1, i_por_rst = 1, o_rvalid, o_remap_ignored;
    logic [3:0] i_chan_off = 4'hF;
    pfr_chan_evt_t [3:0] i_chan_evt = '0;
    pfr_cmd_t i_cmd;
    logic [7:0] o_rdata, r, m, w, f;
    logic [3:0][1:0] o_phys_chan;
    logic [3:0][3:0] o_phys_onehot;
    int err_total = 0, check_count = 0, seed = 83, a, b, c;
    pfr_top u_dut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_cmd(i_cmd),
        .i_por_rst(i_por_rst), .i_chan_evt(i_chan_evt), .o_rdata(o_rdata),
        .i_chan_off(i_chan_off), .o_rvalid(o_rvalid), .o_phys_chan(o_phys_chan),
        .o_remap_ignored(o_remap_ignored), .o_phys_onehot(o_phys_onehot));
    pfr_host_model u_host (.i_ref_clk(i_ref_clk), .i_rdata(o_rdata),
        .o_cmd(i_cmd));
    initial forever #5 i_ref_clk = ~i_ref_clk;
    task automatic chk(input logic [15:0] s, e, input string n);
        check_count++;
        if (s !== e)
        begin
            err_total++;
            $display("ERROR %s exp %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic rdc(input logic [7:0] c, e);
        u_host.xfer(1'b0, c, 8'h00, r);
        chk(o_rvalid, 1'b1, "rvalid");
        chk(r, e, "rdata");
    endtask : rdc
    task automatic ev(input int ch, input pfr_chan_evt_t e);
        @(posedge i_ref_clk);
        i_chan_evt[ch] <= e;
        @(posedge i_ref_clk);
        i_chan_evt[ch] <= '0;
    endtask : ev
    task automatic final_report(input int late);
        err_total += late;
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : final_report
    // Whole run needs well under 2000 cycles
    initial #50000 final_report(1);
    initial
    begin
        repeat (16) @(posedge i_ref_clk);
        i_rst <= 0;
        i_por_rst <= 0;
        f = 8'h00;
        m = PFR_REMAP_RST;
        rdc(PFR_CMD_FAULT_RO, f);
        rdc(PFR_CMD_REMAP, m);
        for (a = 0; a < 4; a++)
        begin
            f[2*a +: 2] = a == 3 ? 2'h3 : 2'(a + 1);
            ev(a, '{1'b0, 1'b1, 1'b0, 1'b0, a == 3, pfr_fault_t'(a % 3 + 1)});
        end
        rdc(PFR_CMD_FAULT_RO, f);
        rdc(PFR_CMD_FAULT_RO, f);
        ev(1, '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, PFR_FLT_NONE});
        f[3:2] = 2'h0;
        ev(2, '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, PFR_FLT_DETECT});
        rdc(PFR_CMD_FAULT_RO, f);
        ev(2, '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, PFR_FLT_DETECT});
        f[5:4] = 2'h1;
        rdc(PFR_CMD_FAULT_RC, f);
        rdc(PFR_CMD_FAULT_RO, 8'h00);
        $display("fault test done");
        for (a = 0; a < 6; a++)
        begin
            b = {$random(seed)} % 4;
            c = (b + 1) % 4;
            w = m;
            w[2*b +: 2] = m[2*c +: 2];
            // Skipping the swap back leaves a duplicate code
            if (a % 3 != 1)
                w[2*c +: 2] = m[2*b +: 2];
            @(posedge i_ref_clk);
            i_chan_off <= a % 3 ? 4'hF : 4'hF ^ (4'h1 << b);
            u_host.xfer(1'b1, PFR_CMD_REMAP, w, r);
            if (a % 3 == 2)
                m = w;
            chk(o_remap_ignored, a % 3 != 2, "ignored");
            chk(o_phys_chan, m, "map");
            chk(o_phys_onehot, {4'h1 << m[7:6], 4'h1 << m[5:4],
                4'h1 << m[3:2], 4'h1 << m[1:0]}, "route");
            // Channels stay off: no turn-on before a new detect cycle
            i_chan_off <= 4'hF;
        end
        $display("remap test done");
        i_rst <= 1;
        @(posedge i_ref_clk);
        i_rst <= 0;
        rdc(PFR_CMD_REMAP, m);
        i_por_rst <= 1;
        @(posedge i_ref_clk);
        i_por_rst <= 0;
        rdc(PFR_CMD_REMAP, PFR_REMAP_RST);
        rdc(8'h33, PFR_UNMAPPED_RD);
        $display("reset test done");
        final_report(0);
    end
endmodule : poweron_fault_and_port_remap_tb
